// File: dv/board_model.sv
// Purpose: board pins around the port block
// Assumes: pad pullup on the general port, no pullup on the bus port
// Notes: a strong pulldown beats any board driver
`timescale 1ns/100ps
`default_nettype none
module board_model
(
  input wire logic [7:0] gp_out,
  input wire logic [7:0] gp_oe,
  input wire logic [7:0] ad_out,
  input wire logic [7:0] ad_oe,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] dev_data,
  output wire logic [7:0] gp_in,
  output wire logic [7:0] ad_in
);
  // undriven bits follow the board driver, else the pullup
  assign gp_in = (gp_oe & gp_out) | (~gp_oe & ((ext_en & ext_val) | ~ext_en));
  // a released data bus is driven by the memory device
  assign ad_in = (ad_oe & ad_out) | (~ad_oe & dev_data);
endmodule
`default_nettype wire

// File: dv/port_pin_and_bus_logic_checker.sv
// Purpose: timing checks on the reset output, bus port and general port
// Assumes: one clock, nrst low resets everything
// Notes: the mode bit mirrors the strap sample taken during power-on reset
`timescale 1ns/100ps
`default_nettype none
module port_checker
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic reset_pin,
  input wire logic power_on_reset,
  input wire logic osc_warmup,
  input wire logic watchdog_reset,
  input wire logic osc_fail,
  input wire logic reset_out_n,
  input wire logic bus_demux_select,
  input wire logic bus_ale,
  input wire logic bus_cycle,
  input wire logic bus_write,
  input wire logic [7:0] bus_addr_lsb,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] ad_out,
  input wire logic [7:0] ad_oe,
  input wire logic [7:0] gp_in,
  input wire logic [7:0] gp_out,
  input wire logic [7:0] gp_oe,
  input wire logic timer_two_trigger_pin,
  input wire logic ext_irq_two,
  input wire logic ext_irq_five
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic dm; // demultiplexed mode as sampled
  logic q1; // a reset cause was seen last cycle
  wire logic cause = reset_pin | osc_warmup | watchdog_reset | osc_fail;
  // pins lag the cause, so skip the cycle after one too
  wire logic quiet = !cause && !q1;
  // strap is only taken while power-on reset is high
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      dm <= 1'b0;
      q1 <= 1'b0;
    end
    else
    begin
      if (power_on_reset)
        dm <= bus_demux_select;
      q1 <= cause;
    end
  end
  property p_rst_out;
    (reset_pin || osc_warmup || watchdog_reset) |=> !reset_out_n;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset output not low");
  property p_no_cause;
    !(cause || power_on_reset) |=> reset_out_n;
  endproperty
  a_no_cause: assert property (p_no_cause) else $error("reset output low");
  property p_mux_addr;
    bus_ale && !bus_cycle && !dm && quiet |=> ad_out == $past(bus_addr_lsb) && ad_oe == 8'hff;
  endproperty
  a_mux_addr: assert property (p_mux_addr) else $error("address not shown");
  property p_wr_data;
    bus_cycle && bus_write && !bus_ale && quiet |=> ad_out == $past(bus_wdata) && ad_oe == 8'hff;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data not driven");
  property p_rd_turn;
    bus_cycle && !bus_write && !bus_ale && quiet |=> ad_oe == 8'h00;
  endproperty
  a_rd_turn: assert property (p_rd_turn) else $error("port not released");
  property p_demux;
    dm && !bus_cycle && quiet |=> ad_out == 8'hff;
  endproperty
  a_demux: assert property (p_demux) else $error("address in demux mode");
  property p_rst_pins;
    reset_pin [*2] |=> ad_out == 8'hff && gp_oe == 8'h00 && gp_out == 8'hff;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins not reset");
  property p_strong_hi;
    $rose(gp_out[3]) && gp_oe[3] |-> ##1 gp_oe[3] ##1 !gp_oe[3];
  endproperty
  a_strong_hi: assert property (p_strong_hi) else $error("strong high wrong");
  property p_trig;
    $rose(gp_in[1]) |-> ##[1:6] timer_two_trigger_pin;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger pin late");
  property p_irq_two;
    $rose(gp_in[4]) |-> ##[1:6] ext_irq_two ##1 !ext_irq_two;
  endproperty
  a_irq_two: assert property (p_irq_two) else $error("rising edge missed");
  property p_irq_five;
    $fell(gp_in[7]) |-> ##[1:6] ext_irq_five;
  endproperty
  a_irq_five: assert property (p_irq_five) else $error("falling edge missed");
endmodule
bind port_pin_and_bus_logic port_checker port_checker_inst (.clock, .nrst, .reset_pin,
  .power_on_reset, .osc_warmup, .watchdog_reset, .osc_fail, .reset_out_n, .bus_demux_select,
  .bus_ale, .bus_cycle, .bus_write, .bus_addr_lsb, .bus_wdata, .ad_out, .ad_oe, .gp_in,
  .gp_out, .gp_oe, .timer_two_trigger_pin, .ext_irq_two, .ext_irq_five);
`default_nettype wire

// File: dv/port_pin_and_bus_logic_tb_top.sv
// Purpose: register and pin tests of the port block
// Assumes: bench drives on the rising edge, samples on the falling edge
// Notes: board driver and memory device live in the board model
`timescale 1ns/100ps
`default_nettype none
`include "port_regs.vh"
module port_pin_and_bus_logic_tb_top;
  logic clock = 1'b0, nrst = 1'b0, reset_pin = 1'b0, power_on_reset = 1'b1;
  logic osc_warmup = 1'b0, watchdog_reset = 1'b0, osc_fail = 1'b0, bus_demux_select = 1'b0;
  logic bus_ale = 1'b0, bus_cycle = 1'b0, bus_write = 1'b1, timer_two_out = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] bus_addr_lsb = 8'h3c, bus_wdata = 8'ha5, ext_en = 8'h00, ext_val = 8'h5a;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire logic [7:0] bus_rdata, ad_in, ad_out, ad_oe, gp_in, gp_out, gp_oe;
  wire logic [31:0] s_axi_rdata;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic reset_out_n, timer_two_ext_pin, timer_two_trigger_pin, ext_irq_two, ext_irq_five;
  wire logic irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  integer miscompares = 0, check_count = 0, i;
  always #5 clock = ~clock;
  port_pin_and_bus_logic port_pin_and_bus_logic_inst (.clock, .nrst, .reset_pin,
    .power_on_reset, .osc_warmup, .watchdog_reset, .osc_fail, .reset_out_n, .bus_demux_select,
    .bus_ale, .bus_cycle, .bus_write, .bus_addr_lsb, .bus_wdata, .bus_rdata, .ad_in, .ad_out,
    .ad_oe, .gp_in, .gp_out, .gp_oe, .timer_two_out, .timer_two_ext_pin,
    .timer_two_trigger_pin, .ext_irq_two, .ext_irq_five, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  board_model board_model_inst (.gp_out, .gp_oe, .ad_out, .ad_oe, .ext_en, .ext_val,
    .dev_data(8'h69), .gp_in, .ad_in);
  // compare and count
  task chk(input [31:0] g, input [31:0] e);
    begin
      check_count++;
      if (g !== e)
      begin
        miscompares++;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clock);
  endtask
  // both channels offered together, each released once taken
  task wr(input [4:0] a, input [7:0] d, input [1:0] er);
    logic ta, tw;
    begin
      ta = 1'b0;
      tw = 1'b0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw))
      begin
        @(negedge clock);
        ta = ta | s_axi_awready;
        tw = tw | s_axi_wready;
        @(posedge clock);
        if (ta)
          s_axi_awvalid <= 1'b0;
        if (tw)
          s_axi_wvalid <= 1'b0;
      end
      do @(negedge clock); while (!s_axi_bvalid);
      chk(s_axi_bresp, er);
      @(posedge clock);
      s_axi_bready <= 1'b0;
    end
  endtask
  // one read: address held until taken, response and data checked at rvalid
  task rd(input [4:0] a, input [31:0] e, input [1:0] er);
    begin
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge clock); while (!s_axi_arready);
      @(posedge clock);
      s_axi_arvalid <= 1'b0;
      do @(negedge clock); while (!s_axi_rvalid);
      chk(s_axi_rresp, er);
      chk(s_axi_rdata, e);
      @(posedge clock);
      s_axi_rready <= 1'b0;
    end
  endtask
  task results;
    begin
      if (miscompares == 0 && check_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // hang guard, far beyond the expected run
  initial
  begin
    #100000;
    miscompares++;
    results;
  end
  initial
  begin
    cyc(1);
    @(posedge clock) nrst <= 1'b1;
    cyc(3);
    @(posedge clock) power_on_reset <= 1'b0;
    rd(`REG_IRQ_STATUS, 32'h0, `RESP_OKAY);
    rd(`REG_GP_LATCH, 32'hff, `RESP_OKAY);
    rd(5'h1c, 32'h0, `RESP_SLVERR);
    // a write with its low byte lane off leaves the latch alone
    s_axi_wstrb <= 4'h0;
    wr(`REG_GP_LATCH, 8'h00, `RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(`REG_GP_LATCH, 32'hff, `RESP_OKAY);
    chk(gp_oe, 8'h00);
    wr(`REG_BUS_RDATA, 8'h00, `RESP_SLVERR);
    chk({gp_out, gp_oe, ad_out}, 24'hff00ff);
    wr(`REG_GP_LATCH, 8'hf7, `RESP_OKAY);
    cyc(8);
    chk({gp_out, gp_oe, gp_in}, 24'hf708f7);
    wr(`REG_GP_LATCH, 8'hff, `RESP_OKAY);
    cyc(4);
    chk(gp_oe, 8'h00);
    @(posedge clock) ext_en <= 8'hff;
    cyc(8);
    rd(`REG_GP_PIN, 32'h5a, `RESP_OKAY);
    chk(timer_two_ext_pin, 1'b0);
    @(posedge clock) ext_val <= 8'h48;
    cyc(8);
    chk(timer_two_trigger_pin, 1'b0);
    @(posedge clock) ext_val <= 8'h5a;
    cyc(8);
    chk(irq, 1'b0);
    wr(`REG_IRQ_MASK, 8'h03, `RESP_OKAY);
    cyc(3);
    chk(irq, 1'b1);
    rd(`REG_IRQ_STATUS, 32'h3, `RESP_OKAY);
    cyc(3);
    chk(irq, 1'b0);
    // timer output pulls bit 0 low only while its alternate use is on
    wr(`REG_CTRL, 8'h02, `RESP_OKAY);
    cyc(3);
    chk({gp_out[0], gp_oe[0]}, 2'b01);
    @(posedge clock) timer_two_out <= 1'b1;
    cyc(4);
    chk({gp_out[0], gp_oe[0]}, 2'b10);
    @(posedge clock) ext_en <= 8'h00;
    wr(`REG_GP_LATCH, 8'h0f, `RESP_OKAY);
    // pin, warm-up and watchdog reset causes in turn
    for (i = 0; i < 3; i++)
    begin
      @(posedge clock) {reset_pin, osc_warmup, watchdog_reset} <= 3'b100 >> i;
      cyc(3);
      chk(reset_out_n, 1'b0);
      @(posedge clock) {reset_pin, osc_warmup, watchdog_reset} <= 3'b000;
      cyc(3);
      chk(reset_out_n, 1'b1);
    end
    rd(`REG_GP_LATCH, 32'hff, `RESP_OKAY);
    @(posedge clock) osc_fail <= 1'b1;
    cyc(3);
    chk(reset_out_n, 1'b1);
    wr(`REG_CTRL, 8'h01, `RESP_OKAY);
    cyc(3);
    chk(reset_out_n, 1'b0);
    @(posedge clock) osc_fail <= 1'b0;
    @(posedge clock) bus_ale <= 1'b1;
    cyc(2);
    chk({ad_out, ad_oe}, 16'h3cff);
    @(posedge clock) {bus_ale, bus_cycle} <= 2'b01;
    cyc(2);
    chk({ad_out, ad_oe}, 16'ha5ff);
    @(posedge clock) bus_write <= 1'b0;
    cyc(3);
    chk({bus_rdata, ad_oe}, 16'h6900);
    @(posedge clock) bus_cycle <= 1'b0;
    rd(`REG_BUS_RDATA, 32'h69, `RESP_OKAY);
    // strap changes count only under power-on reset
    @(posedge clock) {bus_ale, bus_demux_select} <= 2'b11;
    cyc(2);
    chk(ad_out, 8'h3c);
    @(posedge clock) {bus_ale, power_on_reset} <= 2'b01;
    @(posedge clock) {bus_ale, power_on_reset} <= 2'b10;
    cyc(2);
    chk(ad_out, 8'hff);
    rd(`REG_STATUS, 32'h1, `RESP_OKAY);
    results;
  end
endmodule
`default_nettype wire

// File: rtl/port_pin_and_bus_logic.v
// Purpose: reset output, address/data port and quasi-bidirectional general-purpose port
// Assumes: one 100 MHz clock, synchronous active-low system reset, AXI4-Lite registers
// Notes: every output is registered, so pins follow their causes one cycle later
`timescale 1ns/100ps
`default_nettype none
`include "port_regs.vh"

module port_pin_and_bus_logic
#(
  parameter GP_WIDTH = 8, // general-purpose port width
  parameter AD_WIDTH = 8 // address/data port width
)
(
  input wire clock,
  input wire nrst,
  // reset sources
  input wire reset_pin,
  input wire power_on_reset,
  input wire osc_warmup,
  input wire watchdog_reset,
  input wire osc_fail,
  output reg reset_out_n,
  // bus mode strap
  input wire bus_demux_select,
  // internal external-bus controller side
  input wire bus_ale,
  input wire bus_cycle,
  input wire bus_write,
  input wire [AD_WIDTH-1:0] bus_addr_lsb,
  input wire [AD_WIDTH-1:0] bus_wdata,
  output reg [AD_WIDTH-1:0] bus_rdata,
  // address/data pins
  input wire [AD_WIDTH-1:0] ad_in,
  output reg [AD_WIDTH-1:0] ad_out,
  output reg [AD_WIDTH-1:0] ad_oe,
  // general-purpose pins (weak pullup lives in the pad)
  input wire [GP_WIDTH-1:0] gp_in,
  output reg [GP_WIDTH-1:0] gp_out,
  output reg [GP_WIDTH-1:0] gp_oe,
  // peripheral side of the alternate functions
  input wire timer_two_out,
  output reg timer_two_ext_pin,
  output reg timer_two_trigger_pin,
  output reg ext_irq_two,
  output reg ext_irq_five,
  output reg irq,
  // axi4-lite slave
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // strong high driver length, least time rounded up
  localparam integer STRONG_HI_FULL = (`STRONG_HI_NS + `CLOCK_NS - 1) / `CLOCK_NS;
  localparam [3:0] STRONG_HI_CYCLES = STRONG_HI_FULL[3:0]; // counter is four bits wide

  reg [`CTRL_WIDTH-1:0] ctrl; // oscillator-fail enable, timer output enable
  reg [GP_WIDTH-1:0] gp_latch; // software output latch
  reg [`IRQ_WIDTH-1:0] irq_status; // sticky edge events
  reg [`IRQ_WIDTH-1:0] irq_mask; // interrupt gate
  reg demux_mode; // bus mode caught at power-on
  reg [GP_WIDTH-1:0] gp_meta; // first synchroniser stage, read by gp_sync only
  reg [GP_WIDTH-1:0] gp_sync; // synchronized pin level
  reg [GP_WIDTH-1:0] gp_prev; // previous synchronized level, for edges
  reg [4:0] aw_addr; // held write address
  reg aw_held;
  reg [7:0] w_data; // held low byte of write data
  reg w_lane; // low byte lane was enabled
  reg w_held;
  reg [`IRQ_WIDTH-1:0] irq_event; // edges seen this cycle
  wire status_read; // a read of the interrupt status register is taken now
  wire device_reset; // any cause that resets the port logic
  wire soft_reset; // port latches and pins go to reset state
  wire do_write; // both halves of a write are held
  wire [GP_WIDTH-1:0] eff_latch; // latch after alternate function merge
  wire [GP_WIDTH-1:0] rise_to_one; // bits written from 0 to 1 now

  // external pin, warm-up and watchdog always reset; osc fail only if enabled
  assign device_reset = reset_pin | osc_warmup | watchdog_reset
    | (osc_fail & ctrl[`CTRL_OSC_FAIL_EN]);
  assign soft_reset = ~nrst | device_reset;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  // timer two output gates bit 0 low when its alternate function is on
  assign eff_latch = {gp_latch[GP_WIDTH-1:1],
    gp_latch[`GP_TIMER_BIT] & (timer_two_out | ~ctrl[`CTRL_TIMER_OUT_EN])};

  // reset output pin, low while any enabled reset cause stands
  always @(posedge clock)
  begin
    if (!nrst)
      reset_out_n <= 1'b0;
    else
      reset_out_n <= ~device_reset;
  end

  // bus mode strap sampled only while power-on reset stands
  always @(posedge clock)
  begin
    if (!nrst)
      demux_mode <= 1'b0;
    else if (power_on_reset)
      demux_mode <= bus_demux_select;
  end

  // address/data pins; software cannot drive them and only reads bus_rdata from here
  always @(posedge clock)
  begin
    if (soft_reset)
    begin
      ad_out <= `AD_RESET;
      ad_oe <= {AD_WIDTH{1'b1}};
      bus_rdata <= {AD_WIDTH{1'b0}};
    end
    else if (bus_ale && !demux_mode)
    begin
      // address phase only in multiplexed mode
      ad_out <= bus_addr_lsb;
      ad_oe <= {AD_WIDTH{1'b1}};
    end
    else if (bus_cycle && bus_write)
    begin
      // data phase of a write, both modes
      ad_out <= bus_wdata;
      ad_oe <= {AD_WIDTH{1'b1}};
    end
    else if (bus_cycle)
    begin
      // data phase of a read: release and sample
      ad_oe <= {AD_WIDTH{1'b0}};
      bus_rdata <= ad_in;
    end
    else
    begin
      // idle bus rests high, no pullups needed
      ad_out <= `AD_RESET;
      ad_oe <= {AD_WIDTH{1'b1}};
    end
  end

  // two-stage synchroniser and edge history for the port pins
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      gp_meta <= {GP_WIDTH{1'b1}};
      gp_sync <= {GP_WIDTH{1'b1}};
      gp_prev <= {GP_WIDTH{1'b1}};
    end
    else
    begin
      gp_meta <= gp_in;
      gp_sync <= gp_meta;
      gp_prev <= gp_sync;
    end
  end

  // latch bits rising from 0 to 1 on this write
  assign rise_to_one = (do_write && w_lane && aw_addr == `REG_GP_LATCH) ?
    (~gp_latch & w_data[GP_WIDTH-1:0]) : {GP_WIDTH{1'b0}};

  // per-bit pin driver: pulldown at 0, short strong high on 0 to 1, else weak
  genvar i;
  generate
    for (i = 0; i < GP_WIDTH; i = i + 1)
    begin : g_pin
      reg [3:0] strong_left; // cycles of strong high still to go
      always @(posedge clock)
      begin
        if (soft_reset)
        begin
          // latch at 1: only the weak pullup holds the pin
          strong_left <= 4'h0;
          gp_out[i] <= 1'b1;
          gp_oe[i] <= 1'b0;
        end
        else if (rise_to_one[i])
        begin
          // momentary strong driver after a 0 to 1 write
          strong_left <= STRONG_HI_CYCLES - 4'h1;
          gp_out[i] <= 1'b1;
          gp_oe[i] <= 1'b1;
        end
        else if (!eff_latch[i])
        begin
          // strong pulldown stays until a 1 or a reset
          strong_left <= 4'h0;
          gp_out[i] <= 1'b0;
          gp_oe[i] <= 1'b1;
        end
        else if (strong_left != 4'h0)
        begin
          strong_left <= strong_left - 4'h1;
          gp_out[i] <= 1'b1;
          gp_oe[i] <= 1'b1;
        end
        else
        begin
          // released: outside drivers may override, pin is an input
          gp_out[i] <= 1'b1;
          gp_oe[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // alternate function inputs and edge events toward the core
  always @*
  begin
    irq_event = {`IRQ_WIDTH{1'b0}};
    irq_event[`IRQ_TWO] = gp_sync[`GP_IRQ_TWO_BIT] & ~gp_prev[`GP_IRQ_TWO_BIT];
    irq_event[`IRQ_FIVE] = ~gp_sync[`GP_IRQ_FIVE_BIT] & gp_prev[`GP_IRQ_FIVE_BIT];
  end

  always @(posedge clock)
  begin
    if (!nrst)
    begin
      timer_two_ext_pin <= 1'b1;
      timer_two_trigger_pin <= 1'b1;
      ext_irq_two <= 1'b0;
      ext_irq_five <= 1'b0;
    end
    else
    begin
      timer_two_ext_pin <= gp_sync[`GP_TIMER_BIT];
      timer_two_trigger_pin <= gp_sync[`GP_TRIGGER_BIT];
      ext_irq_two <= irq_event[`IRQ_TWO];
      ext_irq_five <= irq_event[`IRQ_FIVE];
    end
  end

  // write channels: address and data taken in either order, then one response
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      aw_held <= 1'b0;
      aw_addr <= 5'h00;
      w_held <= 1'b0;
      w_data <= 8'h00;
      w_lane <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      // ready is a one-cycle offer while its own channel holds nothing and no response is pending
      s_axi_awready <= ~aw_held & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_held & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // status and pin registers are read-only, writes there are refused
        case (aw_addr)
          `REG_CTRL, `REG_GP_LATCH, `REG_IRQ_MASK: s_axi_bresp <= `RESP_OKAY;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // software registers; the address/data port has no write path here
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      ctrl <= `CTRL_RESET;
      irq_mask <= `IRQ_RESET;
    end
    else if (do_write && w_lane)
    begin
      if (aw_addr == `REG_CTRL)
        ctrl <= w_data[`CTRL_WIDTH-1:0];
      if (aw_addr == `REG_IRQ_MASK)
        irq_mask <= w_data[`IRQ_WIDTH-1:0];
    end
  end

  // port latch: any enabled reset cause sets every bit to 1
  always @(posedge clock)
  begin
    if (soft_reset)
      gp_latch <= `GP_LATCH_RESET;
    else if (do_write && w_lane && aw_addr == `REG_GP_LATCH)
      gp_latch <= w_data[GP_WIDTH-1:0];
  end

  // read channel: one read at a time, data one cycle after the address
  assign status_read = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `REG_IRQ_STATUS);

  always @(posedge clock)
  begin
    if (!nrst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        case (s_axi_araddr)
          `REG_CTRL: s_axi_rdata[`CTRL_WIDTH-1:0] <= ctrl;
          `REG_GP_LATCH: s_axi_rdata[GP_WIDTH-1:0] <= gp_latch;
          `REG_GP_PIN: s_axi_rdata[GP_WIDTH-1:0] <= gp_sync;
          `REG_IRQ_STATUS: s_axi_rdata[`IRQ_WIDTH-1:0] <= irq_status;
          `REG_IRQ_MASK: s_axi_rdata[`IRQ_WIDTH-1:0] <= irq_mask;
          `REG_STATUS:
          begin
            s_axi_rdata[`STAT_DEMUX] <= demux_mode;
            s_axi_rdata[`STAT_RESET_OUT] <= ~reset_out_n;
          end
          `REG_BUS_RDATA: s_axi_rdata[AD_WIDTH-1:0] <= bus_rdata;
          default: s_axi_rresp <= `RESP_SLVERR;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // sticky events: a read clears, but an edge in the same cycle survives
  always @(posedge clock)
  begin
    if (!nrst)
      irq_status <= `IRQ_RESET;
    else if (status_read)
      irq_status <= irq_event;
    else
      irq_status <= irq_status | irq_event;
  end

  // level interrupt from unmasked sticky bits, one cycle behind them
  always @(posedge clock)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

endmodule
`default_nettype wire

// File: rtl/port_regs.vh
// Purpose: constants for the reset output, address/data port and general-purpose port block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes: definitions only
`ifndef PORT_REGS_VH
`define PORT_REGS_VH

// register byte offsets
`define REG_CTRL 5'h00
`define REG_GP_LATCH 5'h04
`define REG_GP_PIN 5'h08
`define REG_IRQ_STATUS 5'h0c
`define REG_IRQ_MASK 5'h10
`define REG_STATUS 5'h14
`define REG_BUS_RDATA 5'h18

// control register fields
`define CTRL_OSC_FAIL_EN 0
`define CTRL_TIMER_OUT_EN 1
`define CTRL_WIDTH 2
`define CTRL_RESET 2'h0

// interrupt status and mask fields
`define IRQ_TWO 0
`define IRQ_FIVE 1
`define IRQ_WIDTH 2
`define IRQ_RESET 2'h0

// status register fields
`define STAT_DEMUX 0
`define STAT_RESET_OUT 1

// general-purpose port
`define GP_LATCH_RESET 8'hff
`define GP_TIMER_BIT 0
`define GP_TRIGGER_BIT 1
`define GP_IRQ_TWO_BIT 4
`define GP_IRQ_FIVE_BIT 7

// address/data port
`define AD_RESET 8'hff

// strong high driver time after a 0 to 1 write
`define STRONG_HI_NS 20
`define CLOCK_NS 10

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif
